// ---- design/cpdr_regs.sv ----
`timescale 1ns/1ns
// Behaviour
// - Cursor fetch reads one linear 256-byte region from the start offset.
// - Cursor is 32x32 pixels, each an AND bit and an XOR bit.
// - Each row is two words: AND bits high half, XOR bits low half.
// - Left 16-pixel block sits at the lower word address.
// - Leftmost pixel is the most significant bit of each half.
// - New cursor start offset takes effect at the next frame start.
// - Block decodes 256 bytes at base plus 8300h.
// - While locked, critical registers ignore writes.
// - Reads always return register contents, locked or not.
// - Cursor fetch start comes from the register at 8318h.
// - Frame buffer start at 8310h, compressed buffer start at 8314h.
// - Video buffer start at 8320h, line stride at 8324h.
// - Lock and general configuration registers reset to zero.
// - Fetch uses a 20-bit doubleword offset plus four byte enables.
module cpdr_regs #(
  parameter logic [31:0] CONTROL_SPACE_BASE = 32'h4000_0000,
  // Arbitrary key value
  parameter logic [31:0] UNLOCK_KEY         = 32'h0000_5A5A
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [31:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [3:0]  reg_be,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_ack,
  output logic             write_locked,
  output logic [31:0]      display_general_config,
  output logic [31:0]      display_timing_config,
  output logic [31:0]      pixel_output_config,
  output logic [31:0]      frame_buffer_start,
  output logic [31:0]      compressed_buffer_start,
  output logic [31:0]      video_buffer_start,
  output logic [31:0]      line_stride,
  output logic [31:0]      line_transfer_size,
  input  wire logic        frame_start,
  output logic             mem_req,
  output logic [19:0]      mem_addr,
  output logic [3:0]       mem_be,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             cursor_row_valid,
  output logic [4:0]       cursor_row_index,
  output logic [31:0]      cursor_row_and,
  output logic [31:0]      cursor_row_xor,
  output logic             cursor_busy
);

  logic [31:0] lock_r, lock_nxt;
  logic [31:0] gcfg_r, gcfg_nxt;
  logic [31:0] tcfg_r, tcfg_nxt;
  logic [31:0] ocfg_r, ocfg_nxt;
  logic [31:0] fb_r, fb_nxt;
  logic [31:0] cb_r, cb_nxt;
  logic [31:0] curs_r, curs_nxt;
  logic [31:0] vid_r, vid_nxt;
  logic [31:0] stride_r, stride_nxt;
  logic [31:0] bufsz_r, bufsz_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        ack_r, ack_nxt;

  logic [31:0] rel;
  logic        hit;
  logic [15:0] ofs;
  logic        wr_ok;
  logic [31:0] bmask;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Offset taken from the base, so a base that is not 64K aligned works
  assign rel   = reg_addr - CONTROL_SPACE_BASE;
  assign hit   = (rel >= cpdr_pkg::BLOCK_OFS) &&
                 (rel < cpdr_pkg::BLOCK_OFS + cpdr_pkg::BLOCK_BYTES);
  assign ofs   = {rel[15:2], 2'h0};
  // Lock closed unless the exact key is held
  assign wr_ok = (lock_r == UNLOCK_KEY);
  assign bmask = {{8{reg_be[3]}}, {8{reg_be[2]}},
                  {8{reg_be[1]}}, {8{reg_be[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_comb begin
    lock_nxt   = lock_r;
    gcfg_nxt   = gcfg_r;
    tcfg_nxt   = tcfg_r;
    ocfg_nxt   = ocfg_r;
    fb_nxt     = fb_r;
    cb_nxt     = cb_r;
    curs_nxt   = curs_r;
    vid_nxt    = vid_r;
    stride_nxt = stride_r;
    bufsz_nxt  = bufsz_r;
    if (reg_wr && hit) begin
      // Lock register itself stays writable so software can reopen it
      if (ofs == cpdr_pkg::OFS_LOCK) begin
        lock_nxt = merge(lock_r, reg_wdata, bmask);
      end else if (wr_ok) begin
        unique case (ofs)
          cpdr_pkg::OFS_GCFG:   gcfg_nxt   = merge(gcfg_r, reg_wdata, bmask);
          cpdr_pkg::OFS_TCFG:   tcfg_nxt   = merge(tcfg_r, reg_wdata, bmask);
          cpdr_pkg::OFS_OCFG:   ocfg_nxt   = merge(ocfg_r, reg_wdata, bmask);
          cpdr_pkg::OFS_FB:     fb_nxt     = merge(fb_r, reg_wdata, bmask);
          cpdr_pkg::OFS_CB:     cb_nxt     = merge(cb_r, reg_wdata, bmask);
          cpdr_pkg::OFS_CURS:   curs_nxt   = merge(curs_r, reg_wdata, bmask);
          cpdr_pkg::OFS_VID:    vid_nxt    = merge(vid_r, reg_wdata, bmask);
          cpdr_pkg::OFS_STRIDE: stride_nxt = merge(stride_r, reg_wdata, bmask);
          cpdr_pkg::OFS_BUFSZ:  bufsz_nxt  = merge(bufsz_r, reg_wdata, bmask);
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    ack_nxt   = (reg_wr || reg_rd) && hit;
    if (reg_rd && hit) begin
      // Read path never looks at the lock
      unique case (ofs)
        cpdr_pkg::OFS_LOCK:   rdata_nxt = lock_r;
        cpdr_pkg::OFS_GCFG:   rdata_nxt = gcfg_r;
        cpdr_pkg::OFS_TCFG:   rdata_nxt = tcfg_r;
        cpdr_pkg::OFS_OCFG:   rdata_nxt = ocfg_r;
        cpdr_pkg::OFS_FB:     rdata_nxt = fb_r;
        cpdr_pkg::OFS_CB:     rdata_nxt = cb_r;
        cpdr_pkg::OFS_CURS:   rdata_nxt = curs_r;
        cpdr_pkg::OFS_VID:    rdata_nxt = vid_r;
        cpdr_pkg::OFS_STRIDE: rdata_nxt = stride_r;
        cpdr_pkg::OFS_BUFSZ:  rdata_nxt = bufsz_r;
        default:              rdata_nxt = cpdr_pkg::RSVD_VALUE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lock_r   <= cpdr_pkg::LOCK_RST;
      gcfg_r   <= cpdr_pkg::GCFG_RST;
      tcfg_r   <= cpdr_pkg::OTHER_RST;
      ocfg_r   <= cpdr_pkg::OTHER_RST;
      fb_r     <= cpdr_pkg::OTHER_RST;
      cb_r     <= cpdr_pkg::OTHER_RST;
      curs_r   <= cpdr_pkg::OTHER_RST;
      vid_r    <= cpdr_pkg::OTHER_RST;
      stride_r <= cpdr_pkg::OTHER_RST;
      bufsz_r  <= cpdr_pkg::OTHER_RST;
      rdata_r  <= cpdr_pkg::OTHER_RST;
      ack_r    <= 1'b0;
    end else begin
      lock_r   <= lock_nxt;
      gcfg_r   <= gcfg_nxt;
      tcfg_r   <= tcfg_nxt;
      ocfg_r   <= ocfg_nxt;
      fb_r     <= fb_nxt;
      cb_r     <= cb_nxt;
      curs_r   <= curs_nxt;
      vid_r    <= vid_nxt;
      stride_r <= stride_nxt;
      bufsz_r  <= bufsz_nxt;
      rdata_r  <= rdata_nxt;
      ack_r    <= ack_nxt;
    end
  end

  assign reg_rdata               = rdata_r;
  assign reg_ack                 = ack_r;
  assign write_locked            = !wr_ok;
  assign display_general_config  = gcfg_r;
  assign display_timing_config   = tcfg_r;
  assign pixel_output_config     = ocfg_r;
  assign frame_buffer_start      = fb_r;
  assign compressed_buffer_start = cb_r;
  assign video_buffer_start      = vid_r;
  assign line_stride             = stride_r;
  assign line_transfer_size      = bufsz_r;

  // ----------------------------------------------------------------
  // Cursor pattern fetch
  // ----------------------------------------------------------------
  cpdr_cursor_fetch u_fetch (
    .mclk         (mclk),
    .resetn       (resetn),
    .frame_start  (frame_start),
    .cursor_start (curs_r),
    .mem_req      (mem_req),
    .mem_addr     (mem_addr),
    .mem_be       (mem_be),
    .mem_ack      (mem_ack),
    .mem_rdata    (mem_rdata),
    .row_valid    (cursor_row_valid),
    .row_index    (cursor_row_index),
    .row_and      (cursor_row_and),
    .row_xor      (cursor_row_xor),
    .busy         (cursor_busy)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb_regs @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Own disable: the default one would mask this check entirely
  a_reset_zero: assert property (
    @(posedge mclk) disable iff (1'b0)
      !resetn |=> lock_r == 32'h0000_0000 &&
      gcfg_r == 32'h0000_0000 && write_locked)
    else $error("lock or general config not zero after reset");

  a_lock_blocks: assert property (
    reg_wr && hit && ofs == cpdr_pkg::OFS_GCFG && write_locked
      |=> $stable(display_general_config))
    else $error("locked register accepted a write");

  a_unlocked_write: assert property (
    reg_wr && hit && ofs == cpdr_pkg::OFS_STRIDE && !write_locked &&
      reg_be == 4'hF |=> line_stride == $past(reg_wdata))
    else $error("unlocked write did not land");

  a_key_opens: assert property (
    reg_wr && hit && ofs == cpdr_pkg::OFS_LOCK && reg_be == 4'hF
      |=> write_locked == ($past(reg_wdata) != UNLOCK_KEY))
    else $error("lock state does not follow key");

  a_read_locked: assert property (
    reg_rd && hit && ofs == cpdr_pkg::OFS_CURS && write_locked
      |=> reg_ack && reg_rdata == $past(curs_r))
    else $error("read blocked or wrong under lock");

  a_rsvd_zero: assert property (
    reg_rd && hit && ofs == cpdr_pkg::OFS_RSVD |=> reg_rdata == 32'h0)
    else $error("reserved location read non-zero");

  a_outside_quiet: assert property (
    (reg_wr || reg_rd) && !hit |=> !reg_ack && $stable(reg_rdata))
    else $error("access outside block answered");

  // Past frame_start left out: a restart may move the address
  a_curs_hold: assert property (
    cursor_busy && !frame_start && !$past(frame_start) &&
      $changed(curs_r) |-> $stable(mem_addr) || $past(mem_ack))
    else $error("cursor offset change disturbed current frame");

  a_ack_follows: assert property (
    (reg_wr || reg_rd) && hit |=> reg_ack)
    else $error("access inside block not answered");

  a_rdata_stands: assert property (
    !(reg_rd && hit) |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_lock_read: assert property (
    reg_rd && hit && ofs == cpdr_pkg::OFS_LOCK
      |=> reg_rdata == $past(lock_r))
    else $error("lock register read wrong");

  a_gcfg_write: assert property (
    reg_wr && hit && ofs == cpdr_pkg::OFS_GCFG && !write_locked &&
      reg_be == 4'hF |=> display_general_config == $past(reg_wdata))
    else $error("unlocked general config write did not land");

  a_fb_write: assert property (
    reg_wr && hit && ofs == cpdr_pkg::OFS_FB && !write_locked &&
      reg_be == 4'hF |=> frame_buffer_start == $past(reg_wdata))
    else $error("frame buffer start write did not land");

  a_vid_write: assert property (
    reg_wr && hit && ofs == cpdr_pkg::OFS_VID && !write_locked &&
      reg_be == 4'hF |=> video_buffer_start == $past(reg_wdata))
    else $error("video buffer start write did not land");

  a_curs_locked: assert property (
    reg_wr && hit && ofs == cpdr_pkg::OFS_CURS && write_locked
      |=> $stable(curs_r))
    else $error("locked cursor start accepted a write");

  a_outside_still: assert property (
    reg_wr && !hit |=> $stable(lock_r) && $stable(gcfg_r) &&
      $stable(curs_r))
    else $error("write outside block changed a register");

  c_unlock:  cover property (reg_wr && hit && ofs == cpdr_pkg::OFS_LOCK &&
                             reg_wdata == UNLOCK_KEY);
  c_blocked: cover property (reg_wr && hit && write_locked &&
                             ofs == cpdr_pkg::OFS_FB);
  c_fetch:   cover property (frame_start ##1 cursor_busy);

endmodule : cpdr_regs

// ---- design/cpdr_pkg.sv ----
package cpdr_pkg;

  // ----------------------------------------------------------------
  // Register block placement
  // ----------------------------------------------------------------
  localparam logic [31:0] BLOCK_OFS   = 32'h0000_8300;
  localparam logic [31:0] BLOCK_BYTES = 32'h0000_0100;

  // ----------------------------------------------------------------
  // Register offsets from the control space base
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_LOCK    = 16'h8300;
  localparam logic [15:0] OFS_GCFG    = 16'h8304;
  localparam logic [15:0] OFS_TCFG    = 16'h8308;
  localparam logic [15:0] OFS_OCFG    = 16'h830C;
  localparam logic [15:0] OFS_FB      = 16'h8310;
  localparam logic [15:0] OFS_CB      = 16'h8314;
  localparam logic [15:0] OFS_CURS    = 16'h8318;
  localparam logic [15:0] OFS_RSVD    = 16'h831C;
  localparam logic [15:0] OFS_VID     = 16'h8320;
  localparam logic [15:0] OFS_STRIDE  = 16'h8324;
  localparam logic [15:0] OFS_BUFSZ   = 16'h8328;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] LOCK_RST    = 32'h0000_0000;
  localparam logic [31:0] GCFG_RST    = 32'h0000_0000;
  localparam logic [31:0] OTHER_RST   = 32'h0000_0000;
  localparam logic [31:0] RSVD_VALUE  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Cursor pattern layout
  // ----------------------------------------------------------------
  localparam int          CURS_BYTES  = 256;
  localparam int          CURS_WORDS  = CURS_BYTES / 4;
  localparam int          CURS_DIM    = 32;
  localparam int          MASK_BITS   = 16;
  localparam int          CURS_ALIGN  = 4;
  localparam logic [3:0]  ALL_BYTES   = 4'hF;

endpackage : cpdr_pkg

// ---- design/cpdr_cursor_fetch.sv ----
`timescale 1ns/1ns
module cpdr_cursor_fetch (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        frame_start,
  input  wire logic [31:0] cursor_start,
  output logic             mem_req,
  output logic [19:0]      mem_addr,
  output logic [3:0]       mem_be,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             row_valid,
  output logic [4:0]       row_index,
  output logic [31:0]      row_and,
  output logic [31:0]      row_xor,
  output logic             busy
);

  typedef enum logic {CPDR_IDLE, CPDR_FETCH} cpdr_fetch_t;

  cpdr_fetch_t st_r, st_nxt;
  logic [5:0]  idx_r, idx_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic [31:0] left_r, left_nxt;
  logic        rv_r, rv_nxt;
  logic [4:0]  ri_r, ri_nxt;
  logic [31:0] ra_r, ra_nxt;
  logic [31:0] rx_r, rx_nxt;

  // ----------------------------------------------------------------
  // Fetch sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    idx_nxt  = idx_r;
    addr_nxt = addr_r;
    left_nxt = left_r;
    rv_nxt   = 1'b0;
    ri_nxt   = ri_r;
    ra_nxt   = ra_r;
    rx_nxt   = rx_r;
    if (frame_start) begin
      // Start offset sampled only here, so a mid-frame change waits
      st_nxt   = CPDR_FETCH;
      idx_nxt  = 6'h00;
      // Low address bits dropped: buffer is 16-byte aligned
      addr_nxt = {cursor_start[21:cpdr_pkg::CURS_ALIGN], 2'h0};
    end else if (st_r == CPDR_FETCH && mem_ack) begin
      addr_nxt = addr_r + 20'h00001;
      idx_nxt  = idx_r + 6'h01;
      if (!idx_r[0]) begin
        left_nxt = mem_rdata;
      end else begin
        rv_nxt = 1'b1;
        ri_nxt = idx_r[5:1];
        // Left block lands in the upper half, leftmost pixel at bit 31
        ra_nxt = {left_r[31:16], mem_rdata[31:16]};
        rx_nxt = {left_r[15:0], mem_rdata[15:0]};
      end
      if (idx_r == 6'(cpdr_pkg::CURS_WORDS - 1)) begin
        st_nxt = CPDR_IDLE;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_r   <= CPDR_IDLE;
      idx_r  <= 6'h00;
      addr_r <= 20'h00000;
      left_r <= 32'h0000_0000;
      rv_r   <= 1'b0;
      ri_r   <= 5'h00;
      ra_r   <= 32'h0000_0000;
      rx_r   <= 32'h0000_0000;
    end else begin
      st_r   <= st_nxt;
      idx_r  <= idx_nxt;
      addr_r <= addr_nxt;
      left_r <= left_nxt;
      rv_r   <= rv_nxt;
      ri_r   <= ri_nxt;
      ra_r   <= ra_nxt;
      rx_r   <= rx_nxt;
    end
  end

  assign mem_req   = (st_r == CPDR_FETCH);
  assign mem_addr  = addr_r;
  assign mem_be    = cpdr_pkg::ALL_BYTES;
  assign row_valid = rv_r;
  assign row_index = ri_r;
  assign row_and   = ra_r;
  assign row_xor   = rx_r;
  assign busy      = (st_r == CPDR_FETCH);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb_f @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_fetch_start: assert property (
    frame_start |=> mem_req && mem_addr ==
      {$past(cursor_start[21:4]), 2'h0})
    else $error("cursor fetch did not start at programmed offset");

  a_addr_linear: assert property (
    mem_req && mem_ack && !frame_start && idx_r != 6'h3F
      |=> mem_req && mem_addr == $past(mem_addr) + 20'h00001)
    else $error("cursor fetch address not linear");

  a_fetch_ends: assert property (
    mem_req && mem_ack && idx_r == 6'h3F && !frame_start |=> !mem_req)
    else $error("cursor fetch did not stop after 256 bytes");

  a_row_pack: assert property (
    mem_req && mem_ack && idx_r[0] && !frame_start |=> row_valid &&
      row_and[15:0] == $past(mem_rdata[31:16]) &&
      row_xor[15:0] == $past(mem_rdata[15:0]))
    else $error("cursor row halves packed wrongly");

  a_row_left: assert property (
    row_valid |-> row_and[31:16] == $past(left_r[31:16]))
    else $error("left pixel block not from lower address");

  c_row_done: cover property (row_valid && row_index == 5'h1F);
  c_restart:  cover property (mem_req && frame_start);

endmodule : cpdr_cursor_fetch

// ---- test/cpdr_regs_tb.sv ----
`timescale 1ns/1ns
module testbench;
  // ----------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------
  localparam logic [31:0] BASE = 32'h4000_0000;
  // Arbitrary key value
  localparam logic [31:0] KEY  = 32'h0000_5A5A;
  logic        mclk, resetn, reg_wr, reg_rd, frame_start, mem_ack;
  logic [31:0] reg_addr, reg_wdata, mem_rdata, reg_rdata;
  logic [3:0]  reg_be, mem_be;
  logic        reg_ack, write_locked, mem_req;
  logic        cursor_row_valid, cursor_busy;
  logic [31:0] gcfg, tcfg, ocfg, fbs, cbs, vbs, strd, bsz, r_and, r_xor;
  logic [19:0] mem_addr;
  logic [4:0]  cursor_row_index;
  int          n_errors, comparisons, rows_seen;
  logic [31:0] rd_v;

  cpdr_regs #(.CONTROL_SPACE_BASE(BASE), .UNLOCK_KEY(KEY)) uut (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .write_locked(write_locked),
    .display_general_config(gcfg), .display_timing_config(tcfg),
    .pixel_output_config(ocfg), .frame_buffer_start(fbs),
    .compressed_buffer_start(cbs), .video_buffer_start(vbs),
    .line_stride(strd), .line_transfer_size(bsz),
    .frame_start(frame_start), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_be(mem_be), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .cursor_row_valid(cursor_row_valid),
    .cursor_row_index(cursor_row_index), .cursor_row_and(r_and),
    .cursor_row_xor(r_xor), .cursor_busy(cursor_busy));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [15:0] ofs,
                     input logic [3:0] be, input logic [31:0] d,
                     input logic hit);
    @(posedge mclk);
    reg_wr    <= wr;
    reg_rd    <= ~wr;
    reg_addr  <= BASE + {16'h0000, ofs};
    reg_be    <= be;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_wdata <= ~d;
    #1;
    check("reg_ack", {31'h0, reg_ack}, {31'h0, hit});
    rd_v = reg_rdata;
  endtask : bus

  task automatic rd_chk(input logic [15:0] ofs, input logic [31:0] exp);
    bus(1'b0, ofs, 4'hF, 32'h0000_0000, 1'b1);
    check("reg_rdata", rd_v, exp);
  endtask : rd_chk

  function automatic logic [31:0] pat(input int i);
    return {16'(i * 16'h0101) ^ 16'hF00F, 16'(i * 16'h0301)};
  endfunction : pat

  // Rows leave bit 31 as leftmost pixel, left word first
  always @(posedge mclk) begin
    logic [31:0] w0;
    logic [31:0] w1;
    #1;
    w0 = pat(2 * (rows_seen % 32));
    w1 = pat(2 * (rows_seen % 32) + 1);
    if (cursor_row_valid === 1'b1) begin
      check("row_index", {27'h0, cursor_row_index}, rows_seen % 32);
      check("row_and", r_and, {w0[31:16], w1[31:16]});
      check("row_xor", r_xor, {w0[15:0], w1[15:0]});
      rows_seen++;
    end
  end

  // Answers 64 word requests, some promptly and some late
  task automatic serve(input logic [31:0] start);
    logic [19:0] a0;
    int          k;
    a0 = {start[21:4], 2'b00};
    for (int i = 0; i < 64; i++) begin
      k = 0;
      while (mem_req !== 1'b1 && k < 20) begin
        @(posedge mclk);
        #1;
        k++;
      end
      check("mem_addr", {12'h0, mem_addr}, {12'h0, a0 + 20'(i)});
      check("mem_be", {28'h0, mem_be}, 32'h0000_000F);
      repeat (i % 3) @(posedge mclk);
      @(posedge mclk);
      mem_ack   <= 1'b1;
      mem_rdata <= pat(i);
      @(posedge mclk);
      mem_ack   <= 1'b0;
      mem_rdata <= ~pat(i);
      #1;
    end
  endtask : serve

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    rd_chk(16'h8300, 32'h0000_0000);
    rd_chk(16'h8304, 32'h0000_0000);
    check("write_locked", {31'h0, write_locked}, 32'h1);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_lock;
    bus(1'b1, 16'h8304, 4'hF, 32'h1234_5678, 1'b1);
    rd_chk(16'h8304, 32'h0000_0000);
    check("gcfg", gcfg, 32'h0000_0000);
    bus(1'b1, 16'h8300, 4'hF, KEY, 1'b1);
    check("write_locked", {31'h0, write_locked}, 32'h0);
    bus(1'b1, 16'h8304, 4'hF, 32'hA5A5_0001, 1'b1);
    bus(1'b1, 16'h8300, 4'hF, KEY ^ 32'h0000_0100, 1'b1);
    check("write_locked", {31'h0, write_locked}, 32'h1);
    bus(1'b1, 16'h8304, 4'hF, 32'h0000_0000, 1'b1);
    bus(1'b1, 16'h8318, 4'hF, 32'h0000_1230, 1'b1);
    rd_chk(16'h8318, 32'h0000_0000);
    rd_chk(16'h8304, 32'hA5A5_0001);
    rd_chk(16'h8300, KEY ^ 32'h0000_0100);
    $display("test_lock done");
  endtask : test_lock

  task automatic test_map;
    bus(1'b1, 16'h8300, 4'hF, KEY, 1'b1);
    for (int i = 1; i < 11; i++)
      bus(1'b1, 16'(16'h8300 + 4 * i), 4'hF, 32'hC000_0000 + i, 1'b1);
    bus(1'b1, 16'h8324, 4'h2, 32'h0000_7700, 1'b1);
    check("tcfg", tcfg, 32'hC000_0002);
    check("ocfg", ocfg, 32'hC000_0003);
    check("fbs", fbs, 32'hC000_0004);
    check("cbs", cbs, 32'hC000_0005);
    check("vbs", vbs, 32'hC000_0008);
    check("strd", strd, 32'hC000_7709);
    check("bsz", bsz, 32'hC000_000A);
    rd_chk(16'h8318, 32'hC000_0006);
    rd_chk(16'h831C, 32'h0000_0000);
    bus(1'b1, 16'h83FC, 4'hF, 32'hFFFF_FFFF, 1'b1);
    rd_chk(16'h83FC, 32'h0000_0000);
    bus(1'b1, 16'h8400, 4'hF, 32'h0000_0000, 1'b0);
    bus(1'b0, 16'h82FC, 4'hF, 32'h0000_0000, 1'b0);
    rd_chk(16'h8300, KEY);
    $display("test_map done");
  endtask : test_map

  task automatic test_cursor;
    logic [31:0] s0;
    logic [31:0] s1;
    s0 = 32'h0012_3450;
    s1 = 32'h0003_0A70;
    bus(1'b1, 16'h8318, 4'hF, s0, 1'b1);
    @(posedge mclk);
    frame_start <= 1'b1;
    @(posedge mclk);
    frame_start <= 1'b0;
    fork
      serve(s0);
      begin
        repeat (30) @(posedge mclk);
        bus(1'b1, 16'h8318, 4'hF, s1, 1'b1);
      end
    join
    repeat (3) @(posedge mclk);
    #1;
    check("busy", {31'h0, cursor_busy}, 32'h0);
    check("req", {31'h0, mem_req}, 32'h0);
    check("rows", rows_seen, 32);
    @(posedge mclk);
    frame_start <= 1'b1;
    @(posedge mclk);
    frame_start <= 1'b0;
    serve(s1);
    repeat (3) @(posedge mclk);
    check("rows", rows_seen, 64);
    $display("test_cursor done");
  endtask : test_cursor

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial begin
    #2000000;
    n_errors++;
    finish_test();
  end

  initial begin
    n_errors = 0;
    comparisons = 0;
    rows_seen = 0;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 32'h0000_0000;
    reg_be = 4'h0;
    reg_wdata = 32'h0000_0000;
    frame_start = 1'b0;
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    test_reset();
    test_lock();
    test_map();
    test_cursor();
    finish_test();
  end
endmodule : testbench
